// ---- rtl/amk_regs.sv ----
`default_nettype none
//Behaviour
// - Writing one to clear bit drops pending interrupt
// - CBC: mode words form IV, word0 lowest
// - CTR: mode words form counter block, same order
// - Other modes ignore mode words; still RW, reset zero
// - Sixty-four word write-only key store
// - Key store accessible only while engine idle
// - Chaining field: 0,1 ECB; 2 CTR; 3 CBC
// - Idle flag one unless calculating; resets one
// - Enabled interrupt pends at operation end until cleared
// - Key size: 0=128, 1=192, 2/3=256
module amk_regs
    import amk_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic [31:0]       i_addr,
    input  wire logic [31:0]       i_wdata,
    output logic      [31:0]       o_rdata,
    input  wire logic              i_start,
    input  wire logic              i_done,
    input  wire logic              i_irq_en,
    input  wire logic [1:0]        i_chaining_mode_field,
    input  wire logic [1:0]        i_key_size_field,
    input  wire logic [5:0]        i_key_raddr,
    output logic      [31:0]       o_key_word,
    output logic                   o_idle,
    output logic                   o_interrupt_pending_bit,
    output logic                   o_irq,
    output amk_chain_t             o_chain,
    output amk_keylen_t            o_keylen,
    output logic                   o_use_mode_words,
    output logic      [127:0]      o_mode_block
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic amk_chain_t chain_of(input logic [1:0] f);
        unique case (f)
            AMK_MD_CTR: chain_of = AMK_CHAIN_CTR;
            AMK_MD_CBC: chain_of = AMK_CHAIN_CBC;
            default:    chain_of = AMK_CHAIN_ECB;
        endcase
    endfunction

    function automatic amk_keylen_t keylen_of(input logic [1:0] f);
        unique case (f)
            AMK_KS_128: keylen_of = AMK_KEY_128;
            AMK_KS_192: keylen_of = AMK_KEY_192;
            default:    keylen_of = AMK_KEY_256;
        endcase
    endfunction

    function automatic logic in_keys(input logic [31:0] a);
        in_keys = (a >= AMK_KEY_BASE_ADDR) && (a < AMK_KEY_BASE_ADDR + 32'(AMK_KEY_WORDS * 4));
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] mode_q [AMK_MODE_WORDS];
    logic [31:0] mode_d [AMK_MODE_WORDS];
    logic        idle_q, idle_d;
    logic        pend_q, pend_d;
    logic        clr_hit;
    logic        key_we;
    logic [31:0] rdata_d, rdata_q;
    logic [31:0] koff;

    assign koff    = i_addr - AMK_KEY_BASE_ADDR;
    assign clr_hit = i_wr && (i_addr == AMK_IRQ_CLEAR_ADDR) && i_wdata[AMK_IRQ_CLEAR_BIT];
    assign key_we  = i_wr && in_keys(i_addr) && idle_q;

    // ------------------------------------------------------------
    // Mode words
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < AMK_MODE_WORDS; i++) begin
            mode_d[i] = mode_q[i];
            if (i_wr && (i_addr == AMK_MODE_WORD0_ADDR + 32'(i * 4))) begin
                mode_d[i] = i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < AMK_MODE_WORDS; i++) begin
                mode_q[i] <= AMK_WORD_RESET;
            end
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // Engine status and pending interrupt
    // ------------------------------------------------------------
    always_comb begin
        idle_d = idle_q;
        if (i_start) begin
            idle_d = 1'b0;
        end else if (i_done) begin
            idle_d = 1'b1;
        end
        pend_d = pend_q;
        if (clr_hit) begin
            pend_d = 1'b0;
        end
        if (i_done && !idle_q && i_irq_en) begin
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            idle_q <= AMK_IDLE_RESET;
            pend_q <= 1'b0;
        end else begin
            idle_q <= idle_d;
            pend_q <= pend_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = AMK_WORD_RESET;
        if (i_rd) begin
            for (int i = 0; i < AMK_MODE_WORDS; i++) begin
                if (i_addr == AMK_MODE_WORD0_ADDR + 32'(i * 4)) begin
                    rdata_d = mode_q[i];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_q <= AMK_WORD_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Key store
    // ------------------------------------------------------------
    amk_key_store u_keys (
        .i_clk   (i_clk),
        .i_we    (key_we),
        .i_waddr (koff[7:2]),
        .i_wdata (i_wdata),
        .i_raddr (i_key_raddr),
        .o_rdata (o_key_word)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata                 = rdata_q;
    assign o_idle                  = idle_q;
    assign o_interrupt_pending_bit = pend_q;
    assign o_irq                   = pend_q;
    assign o_chain                 = chain_of(i_chaining_mode_field);
    assign o_keylen                = keylen_of(i_key_size_field);
    assign o_use_mode_words        = (o_chain != AMK_CHAIN_ECB);
    assign o_mode_block            = {mode_q[3], mode_q[2], mode_q[1], mode_q[0]};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    clr_irq_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        clr_hit && !i_done |=> !pend_q) else $error("pending not cleared");
    clr_rd_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_rd && i_addr == AMK_IRQ_CLEAR_ADDR |=> o_rdata == 32'h0) else $error("clear reads nonzero");
    irq_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_done && !idle_q && i_irq_en |=> pend_q) else $error("pending not set");
    irq_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        pend_q && !clr_hit |=> pend_q) else $error("pending lost");
    irq_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_done && !i_irq_en && !pend_q |=> !pend_q) else $error("pending without enable");
    busy_key_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_wr && in_keys(i_addr) && !idle_q
        |=> u_keys.mem_q[$past(koff[7:2])] == $past(u_keys.mem_q[koff[7:2]]))
        else $error("key write while busy");
    key_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_rd && in_keys(i_addr) |=> o_rdata == 32'h0) else $error("key readable");
    mode_rd_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_wr && i_addr == AMK_MODE_WORD3_ADDR ##1 !i_wr ##1 i_rd && i_addr == AMK_MODE_WORD3_ADDR && !i_wr
        |=> o_rdata == $past(i_wdata, 3)) else $error("mode word readback");
    iv_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_wr && i_addr == AMK_MODE_WORD0_ADDR |=> o_mode_block[31:0] == $past(i_wdata))
        else $error("mode word 0 placement");
    iv_high_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_wr && i_addr == AMK_MODE_WORD3_ADDR |=> o_mode_block[127:96] == $past(i_wdata))
        else $error("mode word 3 placement");
    idle_run_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_start |=> !o_idle) else $error("idle during run");
    idle_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_done && !i_start |=> o_idle) else $error("idle not restored");
    chain_map_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_chaining_mode_field == AMK_MD_CBC |-> o_chain == AMK_CHAIN_CBC && o_use_mode_words)
        else $error("chain decode");
    chain_ctr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_chaining_mode_field == AMK_MD_CTR |-> o_chain == AMK_CHAIN_CTR && o_use_mode_words)
        else $error("counter mode decode");
    chain_ecb_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_chaining_mode_field == AMK_MD_ECB0 || i_chaining_mode_field == AMK_MD_ECB1
        |-> o_chain == AMK_CHAIN_ECB && !o_use_mode_words)
        else $error("plain mode decode");
    key_wide_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_key_size_field != AMK_KS_128 && i_key_size_field != AMK_KS_192 |-> o_keylen == AMK_KEY_256)
        else $error("key size decode");
    key_wr_c:  cover property (@(posedge i_clk) key_we);
    irq_c:     cover property (@(posedge i_clk) pend_q ##1 !pend_q);
    busy_c:    cover property (@(posedge i_clk) i_wr && in_keys(i_addr) && !idle_q);
    mode_rd_c: cover property (@(posedge i_clk)
        i_wr && i_addr == AMK_MODE_WORD3_ADDR ##2 i_rd && i_addr == AMK_MODE_WORD3_ADDR);
    ctr_c:     cover property (@(posedge i_clk) o_chain == AMK_CHAIN_CTR && o_use_mode_words);
endmodule
`default_nettype wire

// ---- inc/amk_pkg.sv ----
`default_nettype none
package amk_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [31:0] AMK_IRQ_CLEAR_ADDR  = 32'h30040018;
    localparam logic [31:0] AMK_MODE_WORD0_ADDR = 32'h3004001c;
    localparam logic [31:0] AMK_MODE_WORD1_ADDR = 32'h30040020;
    localparam logic [31:0] AMK_MODE_WORD2_ADDR = 32'h30040024;
    localparam logic [31:0] AMK_MODE_WORD3_ADDR = 32'h30040028;
    localparam logic [31:0] AMK_KEY_BASE_ADDR   = 32'h30040100;
    localparam int          AMK_KEY_WORDS       = 64;
    localparam int          AMK_MODE_WORDS      = 4;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          AMK_IRQ_CLEAR_BIT   = 0;
    localparam logic [31:0] AMK_WORD_RESET      = 32'h0;
    localparam logic        AMK_IDLE_RESET      = 1'h1;
    localparam logic [1:0]  AMK_MD_ECB0         = 2'h0;
    localparam logic [1:0]  AMK_MD_ECB1         = 2'h1;
    localparam logic [1:0]  AMK_MD_CTR          = 2'h2;
    localparam logic [1:0]  AMK_MD_CBC          = 2'h3;
    localparam logic [1:0]  AMK_KS_128          = 2'h0;
    localparam logic [1:0]  AMK_KS_192          = 2'h1;
    typedef enum logic [1:0] {AMK_CHAIN_ECB, AMK_CHAIN_CTR, AMK_CHAIN_CBC} amk_chain_t;
    typedef enum logic [1:0] {AMK_KEY_128, AMK_KEY_192, AMK_KEY_256} amk_keylen_t;
endpackage
`default_nettype wire

// ---- rtl/amk_key_store.sv ----
`default_nettype none
module amk_key_store
    import amk_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_we,
    input  wire logic [5:0]  i_waddr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [5:0]  i_raddr,
    output logic      [31:0] o_rdata
);
    // ------------------------------------------------------------
    // Key word array
    // ------------------------------------------------------------
    logic [31:0] mem_q [AMK_KEY_WORDS];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = mem_q[i_raddr];
endmodule
`default_nettype wire

// ---- tb/amk_host_model.sv ----
`default_nettype none
module amk_host_model
    import amk_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic [31:0] i_rdata,
    output var  logic        o_wr,
    output var  logic        o_rd,
    output var  logic [31:0] o_addr,
    output var  logic [31:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_wr = 1'h0;
        o_rd = 1'h0;
        o_addr = 32'h0;
        o_wdata = 32'h0;
    end
    // ----------------------------------------
    // Single-cycle write, issued whether or not the engine is idle; amk_regs drops key writes while busy
    // ----------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_wr <= 1'h1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'h0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_rd <= 1'h1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'h0;
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// ---- tb/test_amk_regs.sv ----
`default_nettype none
module test_amk_regs
    import amk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk, nrst, wr, rd, start, done, irq_en, idle, pend, irq, use_mw;
    logic [31:0]  addr, wdata, rdata, kword, got;
    logic [1:0]   cmf, ksf;
    logic [5:0]   kra;
    logic [127:0] blk;
    amk_chain_t   chain;
    amk_keylen_t  klen;
    int           n_fail, compares, cyc;
    amk_regs uut (.i_clk(clk), .i_nrst(nrst), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
        .o_rdata(rdata), .i_start(start), .i_done(done), .i_irq_en(irq_en), .i_chaining_mode_field(cmf),
        .i_key_size_field(ksf), .i_key_raddr(kra), .o_key_word(kword), .o_idle(idle),
        .o_interrupt_pending_bit(pend), .o_irq(irq), .o_chain(chain), .o_keylen(klen),
        .o_use_mode_words(use_mw), .o_mode_block(blk));
    amk_host_model host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    always #25 clk = ~clk;
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic kchk(input logic [5:0] k, input logic [31:0] e);
        @(posedge clk);
        kra <= k;
        @(posedge clk);
        #1 chk("key_word", {96'h0, e}, {96'h0, kword});
    endtask
    task automatic pulse(input bit s);
        @(posedge clk);
        if (s) start <= 1'h1;
        else done <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        done <= 1'h0;
        #1;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {clk, nrst, start, done, irq_en, cmf, ksf, kra} = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        #1 chk("idle", 1, idle);
        chk("pending", 0, pend);
        for (int i = 0; i < 4; i++) begin
            host.rd(AMK_MODE_WORD0_ADDR + 4 * i, got);
            chk("mode_rst", 0, got);
            host.wr(AMK_MODE_WORD0_ADDR + 4 * i, 32'ha5a50000 + i);
        end
        for (int i = 0; i < 4; i++) begin
            host.rd(AMK_MODE_WORD0_ADDR + 4 * i, got);
            chk("mode_rw", 32'ha5a50000 + i, got);
        end
        chk("mode_block", 128'ha5a50003_a5a50002_a5a50001_a5a50000, blk);
        host.wr(AMK_MODE_WORD3_ADDR, 32'h5a5a1234);
        host.rd(AMK_MODE_WORD3_ADDR, got);
        chk("mode_back", 32'h5a5a1234, got);
        chk("block_top", 32'h5a5a1234, blk[127:96]);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            cmf <= m[1:0];
            ksf <= m[1:0];
            @(posedge clk);
            #1 chk("chain", m < 2 ? AMK_CHAIN_ECB : m == 2 ? AMK_CHAIN_CTR : AMK_CHAIN_CBC, chain);
            chk("use_mw", m >= 2, use_mw);
            chk("keylen", m == 0 ? AMK_KEY_128 : m == 1 ? AMK_KEY_192 : AMK_KEY_256, klen);
        end
        host.wr(AMK_KEY_BASE_ADDR, 32'h0badf00d);
        host.wr(AMK_KEY_BASE_ADDR + 32'hfc, 32'hc0ffee63);
        kchk(6'h0, 32'h0badf00d);
        kchk(6'h3f, 32'hc0ffee63);
        host.rd(AMK_KEY_BASE_ADDR, got);
        chk("key_read", 0, got);
        host.rd(AMK_IRQ_CLEAR_ADDR, got);
        chk("clear_read", 0, got);
        @(posedge clk);
        irq_en <= 1'h1;
        pulse(1'b1);
        chk("busy", 0, idle);
        host.wr(AMK_KEY_BASE_ADDR, 32'hdeadbeef);
        kchk(6'h0, 32'h0badf00d);
        pulse(1'b0);
        chk("pending", 1, pend);
        chk("irq", 1, irq);
        chk("idle_end", 1, idle);
        host.wr(AMK_IRQ_CLEAR_ADDR, 32'h0);
        #1 chk("pend_hold", 1, pend);
        host.wr(AMK_IRQ_CLEAR_ADDR, 32'h1);
        #1 chk("pend_clr", 0, pend);
        @(posedge clk);
        irq_en <= 1'h0;
        pulse(1'b1);
        pulse(1'b0);
        chk("no_irq", 0, pend);
        @(posedge clk);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        #1 chk("mode_rst2", 0, blk);
        chk("idle_rst2", 1, idle);
        chk("pend_rst2", 0, pend);
        wrap_up();
    end
endmodule
`default_nettype wire
